//--- verilog/fms_pkg.sv
// package of constants and types for the flash array switch and erase guard
// assumes one 200 MHz clock and a cpu that drives a plain register port
package fms_pkg;

	localparam logic [7:0]  OFS_ARRAY_SELECT   = 8'h00;
	localparam logic [7:0]  OFS_DOWNLOAD_TGT   = 8'h04;
	localparam logic [7:0]  OFS_CODE_CTRL      = 8'h08;
	localparam logic [7:0]  OFS_FLASH_KEY      = 8'h0c;
	localparam logic [7:0]  OFS_DATA_POINTER   = 8'h10;
	localparam logic [7:0]  OFS_IRQ_STATUS     = 8'h14;
	localparam logic [7:0]  OFS_IRQ_MASK       = 8'h18;

	localparam int          BIT_DL_REQUEST     = 0;
	localparam int          BIT_PROG_START     = 1;
	localparam int          BIT_ERASE_START    = 2;
	localparam int          BIT_DL_FAIL        = 4;
	localparam int          BIT_OP_FAIL        = 5;
	localparam int          BIT_BUSY           = 7;

	localparam int          IRQ_DL_DONE        = 0;
	localparam int          IRQ_OP_DONE        = 1;
	localparam int          IRQ_ERROR          = 2;

	localparam logic [7:0]  SEL_USER_BOOT      = 8'haa;
	localparam logic [7:0]  SEL_USER           = 8'h00;
	localparam logic [7:0]  KEY_DOWNLOAD       = 8'ha5;
	localparam logic [7:0]  KEY_OPERATE        = 8'h5a;
	localparam logic [7:0]  KEY_CLEAR          = 8'h00;

	localparam logic [31:0] RST_DOWNLOAD_TGT   = 32'h0000_0000;
	localparam logic [31:0] RST_DATA_POINTER   = 32'h0000_0000;
	localparam logic [2:0]  RST_IRQ_MASK       = 3'h0;

	localparam int          CLOCK_MHZ          = 200;
	localparam int          RESET_LONG_US      = 100;
	localparam int          RESET_LONG_CYCLES  = RESET_LONG_US * CLOCK_MHZ;
	localparam int          STACK_BYTES        = 128;

	typedef enum logic [1:0] {
		FMS_ARR_USER,
		FMS_ARR_BOOT,
		FMS_ARR_EMBED
	} fms_array_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} fms_reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} fms_fetch_t;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [31:0] data;
	} fms_ram_wr_t;

endpackage : fms_pkg

//--- verilog/fms_guard.sv
// flash array switch, download and erase guard with register port
// assumes the cpu keeps its code in ram while flash access is forbidden
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module fms_guard #(
	parameter int SWITCH_CYCLES = 8,
	parameter int OP_CYCLES     = 64,
	parameter int DL_WORDS      = 64,
	parameter logic [31:0] FLASH_BASE = 32'h0000_0000,
	parameter logic [31:0] FLASH_SIZE = 32'h0004_0000
) (
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               srst_i,
	// mode strap
	input  wire logic               user_boot_mode_i,
	// register port
	input  wire fms_pkg::fms_reg_req_t reg_i,
	output logic [31:0]             reg_rdata_o,
	// cpu flash fetches
	input  wire fms_pkg::fms_fetch_t fetch_i,
	output logic                    fetch_grant_o,
	output logic                    fetch_stall_o,
	output logic                    access_ok_o,
	// array selection and operation state
	output fms_pkg::fms_array_t     array_sel_o,
	output logic                    op_busy_o,
	output logic                    op_erase_o,
	// embedded storage read and ram copy
	output logic [15:0]             emb_addr_o,
	output logic                    emb_re_o,
	input  wire logic [31:0]        emb_rdata_i,
	output fms_pkg::fms_ram_wr_t    ram_wr_o,
	// interrupt
	output logic                    irq_o
);
	import fms_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SWITCH,
		ST_DOWNLOAD,
		ST_OPERATE,
		ST_LOCKED
	} fms_state_t;

	fms_state_t  state;
	fms_state_t  next_state;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [7:0]  array_select;
	logic [31:0] download_target;
	logic [7:0]  flash_key;
	logic [31:0] data_pointer;
	logic        dl_fail;
	logic        op_fail;
	logic [2:0]  irq_status;
	logic [2:0]  irq_mask;

	wire wr_sel  = reg_i.wr && reg_i.addr == OFS_ARRAY_SELECT;
	wire wr_tgt  = reg_i.wr && reg_i.addr == OFS_DOWNLOAD_TGT;
	wire wr_ctl  = reg_i.wr && reg_i.addr == OFS_CODE_CTRL;
	wire wr_key  = reg_i.wr && reg_i.addr == OFS_FLASH_KEY;
	wire wr_ptr  = reg_i.wr && reg_i.addr == OFS_DATA_POINTER;
	wire wr_ists = reg_i.wr && reg_i.addr == OFS_IRQ_STATUS;
	wire wr_imsk = reg_i.wr && reg_i.addr == OFS_IRQ_MASK;

	wire idle      = state == ST_IDLE;
	wire sel_valid = reg_i.wdata[7:0] == SEL_USER_BOOT ||
	                 reg_i.wdata[7:0] == SEL_USER;
	wire sw_start  = idle && wr_sel && user_boot_mode_i && sel_valid;
	wire dl_req    = idle && wr_ctl && reg_i.wdata[BIT_DL_REQUEST];
	wire dl_ok     = dl_req && flash_key == KEY_DOWNLOAD;
	wire prog_req  = idle && wr_ctl && !reg_i.wdata[BIT_DL_REQUEST] &&
	                 reg_i.wdata[BIT_PROG_START];
	wire erase_req = idle && wr_ctl && !reg_i.wdata[BIT_DL_REQUEST] &&
	                 !reg_i.wdata[BIT_PROG_START] &&
	                 reg_i.wdata[BIT_ERASE_START];
	wire ptr_in_flash = data_pointer >= FLASH_BASE &&
	                    data_pointer - FLASH_BASE < FLASH_SIZE;
	wire key_op    = flash_key == KEY_OPERATE;
	wire prog_ok   = prog_req && key_op && !ptr_in_flash;
	wire erase_ok  = erase_req && key_op;
	wire op_bad    = (prog_req && !prog_ok) || (erase_req && !erase_ok);
	wire last_cnt_sw = count == 16'(SWITCH_CYCLES - 1);
	wire last_cnt_dl = count == 16'(DL_WORDS - 1);
	wire last_cnt_op = count == 16'(OP_CYCLES - 1);
	wire sw_done   = state == ST_SWITCH && last_cnt_sw;
	wire dl_done   = state == ST_DOWNLOAD && last_cnt_dl;
	wire op_done   = state == ST_OPERATE && last_cnt_op;
	wire key_clr   = wr_key && reg_i.wdata[7:0] == KEY_CLEAR;
	wire [2:0] irq_event = {op_bad || (dl_req && !dl_ok), op_done, dl_done};
	wire [2:0] next_irq_status =
	           (irq_status & ~(wr_ists ? reg_i.wdata[2:0] : 3'h0)) |
	           irq_event;
	wire next_access_ok = next_state == ST_IDLE;
	wire boot_sel  = array_select == SEL_USER_BOOT;

	// state sequencing
	always_comb begin
		next_state = state;
		next_count = count + 16'h0001;
		unique case (state)
			ST_IDLE: begin
				next_count = 16'h0000;
				if (sw_start) begin
					next_state = ST_SWITCH;
				end else if (dl_ok) begin
					next_state = ST_DOWNLOAD;
				end else if (prog_ok || erase_ok) begin
					next_state = ST_OPERATE;
				end
			end
			ST_SWITCH: begin
				if (sw_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_DOWNLOAD: begin
				if (dl_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_OPERATE: begin
				if (op_done) begin
					next_state = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				next_count = 16'h0000;
				if (key_clr) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			count <= 16'h0000;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// software registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			array_select    <= user_boot_mode_i ? SEL_USER_BOOT
			                                    : SEL_USER;
			download_target <= RST_DOWNLOAD_TGT;
			flash_key       <= KEY_CLEAR;
			data_pointer    <= RST_DATA_POINTER;
			irq_mask        <= RST_IRQ_MASK;
		end else begin
			if (sw_start) begin
				array_select <= reg_i.wdata[7:0];
			end
			if (wr_tgt && idle) begin
				download_target <= reg_i.wdata;
			end
			if (wr_key) begin
				flash_key <= reg_i.wdata[7:0];
			end
			if (wr_ptr && idle) begin
				data_pointer <= reg_i.wdata;
			end
			if (wr_imsk) begin
				irq_mask <= reg_i.wdata[2:0];
			end
		end
	end

	// result flags, set on each request, sticky until the next one
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			dl_fail    <= 1'b0;
			op_fail    <= 1'b0;
			irq_status <= 3'h0;
			irq_o      <= 1'b0;
		end else begin
			if (dl_req) begin
				dl_fail <= !dl_ok;
			end
			if (prog_req || erase_req) begin
				op_fail <= op_bad;
			end
			irq_status <= next_irq_status;
			irq_o      <= |(next_irq_status & irq_mask);
		end
	end

	// register read data, one cycle after the strobe
	wire [31:0] ctl_read = 32'({(state != ST_IDLE), 1'b0, op_fail,
	                            dl_fail, 4'h0});
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_i.addr)
			OFS_ARRAY_SELECT: rd_mux = {24'h00_0000, array_select};
			OFS_DOWNLOAD_TGT: rd_mux = download_target;
			OFS_CODE_CTRL:    rd_mux = ctl_read;
			OFS_FLASH_KEY:    rd_mux = {24'h00_0000, flash_key};
			OFS_DATA_POINTER: rd_mux = data_pointer;
			OFS_IRQ_STATUS:   rd_mux = {29'h0, irq_status};
			OFS_IRQ_MASK:     rd_mux = {29'h0, irq_mask};
			default:          rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			reg_rdata_o <= reg_i.rd ? rd_mux : 32'h0000_0000;
		end
	end

	// fetch guard and array selection
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			access_ok_o   <= 1'b1;
			fetch_grant_o <= 1'b0;
			fetch_stall_o <= 1'b0;
			array_sel_o   <= user_boot_mode_i ? FMS_ARR_BOOT : FMS_ARR_USER;
			op_busy_o     <= 1'b0;
			op_erase_o    <= 1'b0;
		end else begin
			access_ok_o   <= next_access_ok;
			fetch_grant_o <= fetch_i.valid && idle;
			fetch_stall_o <= fetch_i.valid && !idle;
			if (next_state == ST_DOWNLOAD) begin
				array_sel_o <= FMS_ARR_EMBED;
			end else if (sw_start) begin
				array_sel_o <= reg_i.wdata[7:0] == SEL_USER_BOOT ?
				               FMS_ARR_BOOT : FMS_ARR_USER;
			end else if (state == ST_DOWNLOAD) begin
				array_sel_o <= boot_sel ? FMS_ARR_BOOT : FMS_ARR_USER;
			end
			op_busy_o <= next_state == ST_OPERATE;
			if (idle) begin
				op_erase_o <= erase_ok;
			end
		end
	end

	// routine copy from embedded storage to ram
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			emb_addr_o <= 16'h0000;
			emb_re_o   <= 1'b0;
			ram_wr_o   <= '0;
		end else begin
			emb_addr_o    <= next_state == ST_DOWNLOAD ? next_count : 16'h0000;
			emb_re_o      <= next_state == ST_DOWNLOAD;
			ram_wr_o.we   <= emb_re_o;
			ram_wr_o.addr <= download_target + {14'h0000, emb_addr_o, 2'b00};
			ram_wr_o.data <= emb_rdata_i;
		end
	end

	stall_off_idle_a: assert property (@(posedge clock_i) disable iff (srst_i)
		!idle |=> !fetch_grant_o)
		else $error("fetch granted while flash access forbidden");

	ok_follows_state_a: assert property (@(posedge clock_i)
		disable iff (srst_i) (state == ST_OPERATE) |-> !access_ok_o)
		else $error("access allowed during operation");

	embed_in_dl_a: assert property (@(posedge clock_i) disable iff (srst_i)
		state == ST_DOWNLOAD |-> array_sel_o == FMS_ARR_EMBED)
		else $error("embedded array not selected in download");

	ram_copy_addr_a: assert property (@(posedge clock_i)
		disable iff (srst_i) ram_wr_o.we |-> ram_wr_o.addr ==
		$past(download_target) + {14'h0000, $past(emb_addr_o), 2'b00})
		else $error("ram copy address off download target");

	lock_until_key_a: assert property (@(posedge clock_i)
		disable iff (srst_i)
		state == ST_LOCKED && !key_clr |=> state == ST_LOCKED)
		else $error("lock left without clearing the key");

	ptr_flash_err_a: assert property (@(posedge clock_i) disable iff (srst_i)
		prog_req && ptr_in_flash |=> op_fail && idle && irq_status[2])
		else $error("program with flash data pointer not refused");

	dl_key_check_a: assert property (@(posedge clock_i) disable iff (srst_i)
		dl_req && flash_key != KEY_DOWNLOAD |=> dl_fail && idle)
		else $error("download started without download key");

	boot_reset_sel_a: assert property (@(posedge clock_i)
		$past(srst_i) && $past(user_boot_mode_i) && !srst_i |->
		array_select == SEL_USER_BOOT)
		else $error("user boot reset did not select boot array");

	set_wins_clr_a: assert property (@(posedge clock_i) disable iff (srst_i)
		dl_done && wr_ists && reg_i.wdata[0] |=> irq_status[0])
		else $error("download done event lost on clear");

	switch_len_a: assert property (@(posedge clock_i) disable iff (srst_i)
		sw_start |=> (state == ST_SWITCH)[*8] ##1 idle)
		else $error("array switch window wrong length");

endmodule : fms_guard

//--- sim/tb_fms_guard.sv
// testbench for the flash array switch and erase guard
// assumes reads answer one cycle late and the register port never waits
`timescale 1ns/10ps
module tb_fms_guard;
	import fms_pkg::*;

	localparam int DLW = 4;

	logic         clock_i          = 1'b0;
	logic         srst_i           = 1'b1;
	logic         user_boot_mode_i = 1'b1;
	fms_reg_req_t reg_q            = '0;
	fms_fetch_t   fetch_q          = '0;
	logic [31:0]  reg_rdata_o;
	logic         fetch_grant_o;
	logic         fetch_stall_o;
	logic         access_ok_o;
	fms_array_t   array_sel_o;
	logic         op_busy_o;
	logic         op_erase_o;
	logic [15:0]  emb_addr_o;
	logic         emb_re_o;
	logic [31:0]  emb_rdata_i;
	fms_ram_wr_t  ram_wr_o;
	logic         irq_o;
	logic [63:0]  notes[$];
	int           mismatches  = 0;
	int           check_count = 0;
	int           seed        = 60537;
	int           ram_cnt     = 0;
	logic [31:0]  tgt;
	logic         rd_seen     = 1'b0;
	logic         v_d         = 1'b0;
	logic         ok_d        = 1'b0;
	logic         rst_d       = 1'b1;

	always #2.5 clock_i = ~clock_i;
	assign emb_rdata_i = {emb_addr_o ^ 16'hc3a5, emb_addr_o};

	fms_guard #(.SWITCH_CYCLES(8), .OP_CYCLES(4), .DL_WORDS(DLW)) i_fms_guard (
		.clock_i          (clock_i),
		.srst_i           (srst_i),
		.user_boot_mode_i (user_boot_mode_i),
		.reg_i            (reg_q),
		.reg_rdata_o      (reg_rdata_o),
		.fetch_i          (fetch_q),
		.fetch_grant_o    (fetch_grant_o),
		.fetch_stall_o    (fetch_stall_o),
		.access_ok_o      (access_ok_o),
		.array_sel_o      (array_sel_o),
		.op_busy_o        (op_busy_o),
		.op_erase_o       (op_erase_o),
		.emb_addr_o       (emb_addr_o),
		.emb_re_o         (emb_re_o),
		.emb_rdata_i      (emb_rdata_i),
		.ram_wr_o         (ram_wr_o),
		.irq_o            (irq_o)
	);

	task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e,
		input logic [31:0] m);
		check_count++;
		if ((g & m) !== (e & m)) begin
			mismatches++;
			$display("mismatch at %0t read got %h exp %h", $time, g, e);
		end
	endtask : cmp_rd

	task automatic cmp_lvl(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t level got %h exp %h", $time, g, e);
		end
	endtask : cmp_lvl

	task automatic cmp_ram(input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t ram got %h exp %h", $time, g, e);
		end
	endtask : cmp_ram

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_q <= '{1'b1, 1'b0, a, d};
		@(posedge clock_i);
		reg_q <= '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clock_i);
		notes.push_back({e, m});
		reg_q <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clock_i);
		reg_q <= '0;
	endtask : rd

	task automatic wait_ok;
		for (int n = 0; n < 300 && access_ok_o !== 1'b1; n++) step(1);
	endtask : wait_ok

	// result watcher and random fetch traffic
	always @(posedge clock_i) begin
		if (rd_seen) begin
			cmp_rd(reg_rdata_o, notes[0][63:32], notes[0][31:0]);
			void'(notes.pop_front());
		end
		if (ram_wr_o.we === 1'b1) begin
			cmp_ram({ram_wr_o.addr, ram_wr_o.data}, {tgt + 32'(4 * ram_cnt),
				16'(ram_cnt) ^ 16'hc3a5, 16'(ram_cnt)});
			ram_cnt++;
		end
		if (v_d && !rst_d && !srst_i) begin
			cmp_lvl(32'(fetch_grant_o), 32'(ok_d));
			cmp_lvl(32'(fetch_stall_o), 32'(!ok_d));
		end
		rd_seen <= reg_q.rd;
		v_d     <= fetch_q.valid;
		ok_d    <= access_ok_o;
		rst_d   <= srst_i;
		fetch_q <= '{1'($random(seed)), $random(seed)};
	end

	initial begin
		// target leaves room above it for the routine and its stack
		tgt = {16'h00ff, 16'($random(seed)) & 16'h7ffc};
		repeat (3) @(posedge clock_i);
		srst_i <= 1'b0;
		rd(OFS_ARRAY_SELECT, 32'haa, 32'hff);
		rd(OFS_FLASH_KEY, 32'h0, 32'hff);
		rd(OFS_IRQ_MASK, 32'h0, 32'h7);
		rd(OFS_IRQ_STATUS, 32'h0, 32'h7);
		rd(8'h1c, 32'h0, 32'hffff_ffff);
		step(1);
		cmp_lvl(32'(array_sel_o), 32'(FMS_ARR_BOOT));
		// download with the right key
		wr(OFS_DOWNLOAD_TGT, tgt);
		wr(OFS_FLASH_KEY, 32'(KEY_DOWNLOAD));
		wr(OFS_CODE_CTRL, 32'h1 << BIT_DL_REQUEST);
		step(1);
		cmp_lvl(32'(array_sel_o), 32'(FMS_ARR_EMBED));
		cmp_lvl(32'(access_ok_o), 32'h0);
		// clear the done bit in the very cycle that sets it
		step(DLW - 3);
		wr(OFS_IRQ_STATUS, 32'h1);
		wait_ok;
		cmp_lvl(32'(access_ok_o), 32'h1);
		step(1);
		cmp_lvl(32'(ram_cnt), 32'(DLW));
		cmp_lvl(32'(irq_o), 32'h0);
		wr(OFS_IRQ_MASK, 32'h1);
		step(1);
		cmp_lvl(32'(irq_o), 32'h1);
		rd(OFS_IRQ_STATUS, 32'h1, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h7);
		step(1);
		cmp_lvl(32'(irq_o), 32'h0);
		// download and operate with wrong keys, program data inside flash
		wr(OFS_IRQ_MASK, 32'h4);
		wr(OFS_FLASH_KEY, 32'h33);
		wr(OFS_CODE_CTRL, 32'h1 << BIT_DL_REQUEST);
		step(2);
		cmp_lvl(32'(access_ok_o), 32'h1);
		cmp_lvl(32'(irq_o), 32'h1);
		rd(OFS_CODE_CTRL, 32'h10, 32'h10);
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_DATA_POINTER, 32'h0010_0000);
		wr(OFS_FLASH_KEY, 32'(KEY_DOWNLOAD));
		wr(OFS_CODE_CTRL, 32'h1 << BIT_PROG_START);
		step(2);
		cmp_lvl(32'(op_busy_o), 32'h0);
		cmp_lvl(32'(irq_o), 32'h1);
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_DATA_POINTER, 32'h0000_0100);
		wr(OFS_FLASH_KEY, 32'(KEY_OPERATE));
		wr(OFS_CODE_CTRL, 32'h1 << BIT_PROG_START);
		step(2);
		cmp_lvl(32'(op_busy_o), 32'h0);
		cmp_lvl(32'(irq_o), 32'h1);
		rd(OFS_CODE_CTRL, 32'h20, 32'h20);
		wr(OFS_IRQ_STATUS, 32'h7);
		// program then erase, each locked until the key is cleared
		wr(OFS_DATA_POINTER, 32'h0010_0000);
		for (int k = 1; k <= 2; k++) begin
			wr(OFS_FLASH_KEY, 32'(KEY_OPERATE));
			wr(OFS_CODE_CTRL, 32'h1 << k);
			step(1);
			cmp_lvl(32'(op_busy_o), 32'h1);
			cmp_lvl(32'(access_ok_o), 32'h0);
			cmp_lvl(32'(op_erase_o), 32'(k == 2));
			rd(OFS_CODE_CTRL, 32'h80, 32'h80);
			for (int n = 0; n < 300 && op_busy_o !== 1'b0; n++) step(1);
			step(3);
			cmp_lvl(32'(access_ok_o), 32'h0);
			wr(OFS_FLASH_KEY, 32'(KEY_CLEAR));
			wait_ok;
			cmp_lvl(32'(access_ok_o), 32'h1);
		end
		// switch to the user array and back
		rd(OFS_ARRAY_SELECT, 32'haa, 32'hff);
		wr(OFS_ARRAY_SELECT, 32'(SEL_USER));
		step(1);
		cmp_lvl(32'(array_sel_o), 32'(FMS_ARR_USER));
		step(3);
		cmp_lvl(32'(access_ok_o), 32'h0);
		wait_ok;
		rd(OFS_ARRAY_SELECT, 32'h0, 32'hff);
		wr(OFS_ARRAY_SELECT, 32'(SEL_USER_BOOT));
		step(1);
		cmp_lvl(32'(array_sel_o), 32'(FMS_ARR_BOOT));
		wait_ok;
		wr(OFS_ARRAY_SELECT, 32'h55);
		step(2);
		cmp_lvl(32'(access_ok_o), 32'h1);
		// long reset in mid operation, then outside user boot mode
		wr(OFS_FLASH_KEY, 32'(KEY_OPERATE));
		wr(OFS_CODE_CTRL, 32'h1 << BIT_ERASE_START);
		step(1);
		cmp_lvl(32'(op_busy_o), 32'h1);
		@(posedge clock_i);
		srst_i           <= 1'b1;
		user_boot_mode_i <= 1'b0;
		repeat (RESET_LONG_CYCLES) @(posedge clock_i);
		srst_i <= 1'b0;
		rd(OFS_ARRAY_SELECT, 32'h0, 32'hff);
		wr(OFS_ARRAY_SELECT, 32'(SEL_USER_BOOT));
		step(2);
		cmp_lvl(32'(array_sel_o), 32'(FMS_ARR_USER));
		cmp_lvl(32'(op_busy_o), 32'h0);
		cmp_lvl(32'(access_ok_o), 32'h1);
		step(2);
		end_sim();
	end

	initial begin
		#(RESET_LONG_CYCLES * 5 + 20000);
		mismatches++;
		end_sim();
	end
endmodule : tb_fms_guard
